// >>> design/rotate_left_through_carry.v
// Purpose: one rotate-left-through-carry instruction over the data memory
// Assumes: data memory read is combinational on MEM_ADDR_O/MEM_RDATA_I
// Notes: four clocks per instruction: decode, read, process, write
//        a start during an instruction is ignored without indication
//        flags other than carry, zero and negative stay zero
//
// Contract
// - rotate addressed byte left one place with carry as ninth bit
// - destination 0 writes result to working register, file untouched
// - destination 1 writes result back to the same file register
// - bank access 0 addresses access bank, bank select register ignored
// - bank access 1 uses bank select register to pick register bank
// - access 0, extended set on, address up to 95: indexed literal offset
`timescale 1ns/1ps
`include "rot_defines.vh"
module rotate_left_through_carry (
	// clock and reset
	input  wire        MCLK_I,
	input  wire        RESET_I,
	// instruction
	input  wire        START_I,
	input  wire [7:0]  FADDR_I,
	input  wire        DEST_I,
	input  wire        BANK_ACCESS_I,
	input  wire        EXT_SET_I,
	input  wire [3:0]  BANK_SELECT_I,
	input  wire [11:0] INDEX_BASE_I,
	// data memory
	input  wire [7:0]  MEM_RDATA_I,
	output reg  [11:0] MEM_ADDR_O,
	output reg  [7:0]  MEM_WDATA_O,
	output reg         MEM_WE_O,
	// results
	output reg  [7:0]  WREG_O,
	output reg  [4:0]  STATUS_O,
	output reg         BUSY_O,
	output reg         DONE_O
);

	// instruction phases, one clock each
	// binary phase codes in the order the phases run
	localparam [1:0] q_decode  = 2'h0;
	localparam [1:0] q_read    = 2'h1;
	localparam [1:0] q_process = 2'h2;
	localparam [1:0] q_write   = 2'h3;

	// phase register and the operand state carried between phases
	reg [1:0]  q_q;
	reg [1:0]  q_d;
	reg        dest_q;
	reg        dest_d;
	reg [7:0]  res_q;
	reg [7:0]  res_d;
	reg        cout_q;
	reg        cout_d;

	// decoded operand address and the rotation of the read byte
	reg [11:0] addr_d;
	reg [8:0]  rot_d;
	wire       start_ok;

	// next values of the output flip-flops
	reg [11:0] mem_addr_d;
	reg [7:0]  mem_wdata_d;
	reg        mem_we_d;
	reg [7:0]  wreg_d;
	reg [4:0]  status_d;
	reg        busy_d;
	reg        done_d;

	// nine-bit rotate: carry out on top, rotated byte below
	// the old carry enters at bit 0 and bit 7 leaves as the new carry
	function [8:0] rotate_through_carry;
		input [7:0] value;
		input       carry_in;
		begin
			rotate_through_carry = {value, carry_in};
		end
	endfunction

	// flag word after a result; unused flag positions read as zero
	function [4:0] flags_after;
		input [7:0] result;
		input       carry_out;
		begin
			flags_after             = `STATUS_RESET;
			flags_after[`CARRY_BIT] = carry_out;
			flags_after[`ZERO_BIT]  = (result == 8'h00);
			flags_after[`NEG_BIT]   = result[7];
		end
	endfunction

	// operand address for the selected addressing mode
	// bank select wins whenever chosen; indexing only applies to the access bank
	function [11:0] operand_addr;
		input        bank_access;
		input        ext_set;
		input [7:0]  faddr;
		input [3:0]  bank_select;
		input [11:0] index_base;
		begin
			if (bank_access == `BANK_SELECTED) begin
				operand_addr = {bank_select, faddr};
			end else if (ext_set && (faddr <= `INDEXED_MAX)) begin
				operand_addr = index_base + {`ACCESS_LOW_BANK, faddr};
			end else if (faddr < `ACCESS_SPLIT) begin
				operand_addr = {`ACCESS_LOW_BANK, faddr};
			end else begin
				operand_addr = {`ACCESS_HIGH_BANK, faddr};
			end
		end
	endfunction

	// start accepted only between instructions; others are dropped silently
	assign start_ok = START_I && !BUSY_O;

	// operand address decode from the instruction fields
	// the indexed sum wraps inside the 12-bit data space
	always @* begin
		addr_d = operand_addr(BANK_ACCESS_I, EXT_SET_I, FADDR_I, BANK_SELECT_I, INDEX_BASE_I);
	end

	// rotation of the byte on the read bus
	// carry in is the flag left by the previous instruction
	always @* begin
		rot_d = rotate_through_carry(MEM_RDATA_I, STATUS_O[`CARRY_BIT]);
	end

	// next values per phase; strobes fall back to idle each cycle
	// every other register holds by default, so no path leaves a latch
	always @* begin
		q_d         = q_q;
		dest_d      = dest_q;
		res_d       = res_q;
		cout_d      = cout_q;
		mem_addr_d  = MEM_ADDR_O;
		mem_wdata_d = MEM_WDATA_O;
		mem_we_d    = `STROBE_RESET;
		wreg_d      = WREG_O;
		status_d    = STATUS_O;
		busy_d      = BUSY_O;
		done_d      = `STROBE_RESET;
		case (q_q)
			q_decode: begin
				// capture address and destination of a taken start
				if (start_ok) begin
					mem_addr_d = addr_d;
					dest_d     = DEST_I;
					busy_d     = 1'b1;
					q_d        = q_read;
				end
			end
			q_read: begin
				// read data is taken at the end of this phase
				res_d  = rot_d[7:0];
				cout_d = rot_d[8];
				q_d    = q_process;
			end
			q_process: begin
				// flags settle one cycle ahead of the working register
				status_d = flags_after(res_q, cout_q);
				if (dest_q == `DEST_FILE) begin
					mem_wdata_d = res_q;
					mem_we_d    = 1'b1;
				end
				q_d = q_write;
			end
			q_write: begin
				// working register load and end of instruction
				if (dest_q == `DEST_WORKING) begin
					wreg_d = res_q;
				end
				busy_d = 1'b0;
				done_d = 1'b1;
				q_d    = q_decode;
			end
			default: begin
				// unused phase codes return to decode
				q_d = q_decode;
			end
		endcase
	end

	// phase register and operand state
	always @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			q_q    <= q_decode;
			dest_q <= `DEST_RESET;
			res_q  <= `RES_RESET;
			cout_q <= `CARRY_RESET;
		end else begin
			q_q    <= q_d;
			dest_q <= dest_d;
			res_q  <= res_d;
			cout_q <= cout_d;
		end
	end

	// output flip-flops; every port is registered
	// strobes rest low after reset
	always @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			MEM_ADDR_O  <= `ADDR_RESET;
			MEM_WDATA_O <= `WDATA_RESET;
			MEM_WE_O    <= `STROBE_RESET;
			WREG_O      <= `W_RESET;
			STATUS_O    <= `STATUS_RESET;
			BUSY_O      <= `STROBE_RESET;
			DONE_O      <= `STROBE_RESET;
		end else begin
			MEM_ADDR_O  <= mem_addr_d;
			MEM_WDATA_O <= mem_wdata_d;
			MEM_WE_O    <= mem_we_d;
			WREG_O      <= wreg_d;
			STATUS_O    <= status_d;
			BUSY_O      <= busy_d;
			DONE_O      <= done_d;
		end
	end

endmodule

// >>> include/rot_defines.vh
// Purpose: constants for the rotate-left-through-carry datapath
// Assumes: 8-bit data, 12-bit data memory address (4-bit bank + 8-bit offset)
// Notes: access bank split, flag positions and reset values live here
`ifndef ROT_DEFINES_VH
`define ROT_DEFINES_VH
`define DEST_WORKING      1'b0
`define DEST_FILE         1'b1
`define BANK_ACCESS       1'b0
`define BANK_SELECTED     1'b1
`define INDEXED_MAX       8'h5F
`define ACCESS_SPLIT      8'h60
`define ACCESS_LOW_BANK   4'h0
`define ACCESS_HIGH_BANK  4'hF
`define CARRY_BIT         0
`define ZERO_BIT          2
`define NEG_BIT           4
`define STATUS_RESET      5'h00
`define W_RESET           8'h00
`define ADDR_RESET        12'h000
`define WDATA_RESET       8'h00
`define RES_RESET         8'h00
`define DEST_RESET        1'b0
`define CARRY_RESET       1'b0
`define STROBE_RESET      1'b0
`endif

// >>> test/rotate_left_through_carry_monitor.sv
// Purpose: port checker for the rotate-left-through-carry block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound into the design at the foot of this file
`timescale 1ns/1ps
module rot_mon (
	// clock and reset
	input wire        MCLK_I,
	input wire        RESET_I,
	// instruction and data memory
	input wire        START_I,
	input wire        DEST_I,
	input wire [7:0]  MEM_RDATA_I,
	input wire [11:0] MEM_ADDR_O,
	input wire [7:0]  MEM_WDATA_O,
	input wire        MEM_WE_O,
	// results
	input wire [7:0]  WREG_O,
	input wire [4:0]  STATUS_O,
	input wire        BUSY_O,
	input wire        DONE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	// a start taken between instructions, and its two destinations
	sequence s_go; START_I && !BUSY_O; endsequence
	sequence s_go_file; s_go ##0 DEST_I; endsequence
	sequence s_go_work; s_go ##0 !DEST_I; endsequence
	a_busy_span: assert property (s_go |=> BUSY_O [*3] ##1 DONE_O) else $error("span");
	a_write_back: assert property (s_go_file |=> !MEM_WE_O [*2] ##1 MEM_WE_O)
		else $error("wb");
	a_keep_file: assert property (s_go_work |=> !MEM_WE_O [*4]) else $error("kf");
	a_addr_hold: assert property (s_go |=> ##1 $stable(MEM_ADDR_O) [*3])
		else $error("operand address moved during instruction");
	a_wreg_kept: assert property (s_go_file |=> $stable(WREG_O) [*4])
		else $error("working register changed on file destination");
	a_rotate_file: assert property (s_go_file |=> ##2
		((MEM_WDATA_O == {$past(MEM_RDATA_I[6:0], 2), $past(STATUS_O[0], 3)})
		&& (STATUS_O[0] == $past(MEM_RDATA_I[7], 2))))
		else $error("rotated byte or carry wrong");
	a_flags_file: assert property (s_go_file |=> ##2
		(MEM_WE_O && (STATUS_O[2] == (MEM_WDATA_O == 8'h00)) && (STATUS_O[4] == MEM_WDATA_O[7])))
		else $error("flags wrong on file destination");
	a_flags_work: assert property (s_go_work |=> ##3
		(DONE_O && (STATUS_O[2] == (WREG_O == 8'h00)) && (STATUS_O[4] == WREG_O[7])))
		else $error("flags wrong on working destination");
endmodule
bind rotate_left_through_carry rot_mon i_mon (
	.MCLK_I      (MCLK_I),
	.RESET_I     (RESET_I),
	.START_I     (START_I),
	.DEST_I      (DEST_I),
	.MEM_RDATA_I (MEM_RDATA_I),
	.MEM_ADDR_O  (MEM_ADDR_O),
	.MEM_WDATA_O (MEM_WDATA_O),
	.MEM_WE_O    (MEM_WE_O),
	.WREG_O      (WREG_O),
	.STATUS_O    (STATUS_O),
	.BUSY_O      (BUSY_O),
	.DONE_O      (DONE_O)
);

// >>> test/rotate_left_through_carry_tb_top.sv
// Purpose: bench; Assumes: 5 ns clock; Notes: self checking
`timescale 1ns/1ps
module rotate_left_through_carry_tb_top;
	reg MCLK_I = 0, RESET_I = 1, START_I = 0, DEST_I = 0, BANK_ACCESS_I = 0, EXT_SET_I = 0;
	reg [7:0] FADDR_I = 8'h00, MEM_RDATA_I = 8'h00;
	reg [8:0] r = 9'h000;
	reg [7:0] w = 8'h00;
	reg [3:0] BANK_SELECT_I = 4'h3;
	reg [11:0] INDEX_BASE_I = 12'hFF0;
	wire [11:0] MEM_ADDR_O;
	wire [7:0] MEM_WDATA_O, WREG_O;
	wire [4:0] STATUS_O;
	wire MEM_WE_O, BUSY_O, DONE_O;
	int miscompares, num_checks;
	rotate_left_through_carry i_dut (
		.MCLK_I        (MCLK_I),
		.RESET_I       (RESET_I),
		.START_I       (START_I),
		.FADDR_I       (FADDR_I),
		.DEST_I        (DEST_I),
		.BANK_ACCESS_I (BANK_ACCESS_I),
		.EXT_SET_I     (EXT_SET_I),
		.BANK_SELECT_I (BANK_SELECT_I),
		.INDEX_BASE_I  (INDEX_BASE_I),
		.MEM_RDATA_I   (MEM_RDATA_I),
		.MEM_ADDR_O    (MEM_ADDR_O),
		.MEM_WDATA_O   (MEM_WDATA_O),
		.MEM_WE_O      (MEM_WE_O),
		.WREG_O        (WREG_O),
		.STATUS_O      (STATUS_O),
		.BUSY_O        (BUSY_O),
		.DONE_O        (DONE_O)
	);
	initial forever #2.5 MCLK_I = ~MCLK_I;
	task end_sim(input bit t);
		miscompares += t;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input [11:0] s, e);
		num_checks++;
		if (s !== e) $display("unexpected %s exp %h saw %h", n, e, s);
		if (s !== e) miscompares++;
	endtask
	// one instruction; r holds next carry over the expected result
	task op(input [7:0] f, input [2:0] dae, input [7:0] v, input [11:0] ea);
		{DEST_I, BANK_ACCESS_I, EXT_SET_I, FADDR_I, MEM_RDATA_I, START_I} = {dae, f, v, 1'b1};
		r = {v, r[8]};
		@(posedge MCLK_I) #1 START_I = 0;
		chk("addr", MEM_ADDR_O, ea);
		repeat (2) @(posedge MCLK_I);
		#1 if (DEST_I) chk("wdata", MEM_WDATA_O, r[7:0]);
		chk("we", MEM_WE_O, DEST_I);
		@(posedge MCLK_I) #1 if (!DEST_I) w = r[7:0];
		chk("wreg", WREG_O, w);
		chk("status", STATUS_O, {r[7], 1'b0, !r[7:0], 1'b0, r[8]});
	endtask
	task t_ops;
		op(8'h21, 3'b110, 8'h80, 12'h321);
		op(8'h5F, 3'b001, 8'h7F, 12'h04F);
		op(8'hA5, 3'b101, 8'h55, 12'hFA5);
		op(8'h3C, 3'b000, 8'h01, 12'h03C);
		op(8'h10, 3'b011, 8'hC3, 12'h310);
		$display("ops test done");
	endtask
	// start held high through a whole instruction: later starts are refused
	task t_busy;
		{DEST_I, BANK_ACCESS_I, EXT_SET_I, FADDR_I, MEM_RDATA_I, START_I} = {3'b110, 8'h44, 8'h01, 1'b1};
		r = {8'h01, r[8]};
		@(posedge MCLK_I) #1 FADDR_I = 8'h55;
		repeat (2) @(posedge MCLK_I);
		#1 chk("busy addr", MEM_ADDR_O, 12'h344);
		chk("busy wdata", MEM_WDATA_O, r[7:0]);
		chk("busy we", MEM_WE_O, 1'b1);
		@(posedge MCLK_I) #1 START_I = 0;
		@(posedge MCLK_I) #1 chk("busy idle", MEM_ADDR_O, 12'h344);
		chk("busy status", STATUS_O, {r[7], 1'b0, !r[7:0], 1'b0, r[8]});
		$display("busy test done");
	endtask
	initial begin
		#78.5 RESET_I = 0;
		t_ops;
		t_busy;
		end_sim(0);
	end
	initial #1000 end_sim(1);
endmodule
